// File: design/erase_defs.svh
`ifndef ERASE_DEFS_SVH
`define ERASE_DEFS_SVH
// Contract
// - Standard page erase: 81h, dummy, 13 page bits.
// - Binary page erase: 81h, two dummies, BINARY_PAGE_ADDRESS_BITS.
// - Page erase on chip-select rise, timed, ones.
// - Busy shows for whole erase, then ready.
// - Failed verify sets erase/program error flag.
// - Standard block erase: 50h, PA12-PA3 address.
// - Binary block erase: 50h, A21-A12 address.
// - Block erase clears eight aligned pages.
// - Sector erase 7Ch; one of 65 sectors.
// - Standard sector 0a/0b: PA12-PA3 address.
// - Standard sectors 1-63: PA12-PA7 address.
// - Binary sector 0a/0b: A21-A12 address.
// - Binary sectors 1-63: A21-A16 address.
// - Any address inside sector selects it.

// Opcodes and command framing.
`define OP_PAGE_ERASE    8'h81
`define OP_BLOCK_ERASE   8'h50
`define OP_SECTOR_ERASE  8'h7C
`define CMD_BITS         6'h20
`define CMD_BITS_MAX     6'h3F
// Page field inside the 24 address bits.
`define STD_PAGE_MSB     22
`define STD_PAGE_LSB     10
`define BIN_PAGE_MSB     21
`define BIN_PAGE_LSB     9
// Erase extents in pages.
`define PAGE_COUNT_ONE   8'h01
`define BLOCK_PAGES      8'h08
`define SECTOR0B_PAGES   8'h78
`define SECTOR_PAGES     8'h80
`define SECTOR0B_FIRST   13'h0008
// Timing.
`define CLK_KHZ            40000
`define PAGE_ERASE_MAX_MS  25
`define BLOCK_ERASE_MAX_MS 50
`define SECTOR_ERASE_MAX_MS 1000
`define VERIFY_MARGIN      300
`endif

// File: design/erase_pkg.sv
package erase_pkg;
  typedef enum logic [1:0] {ST_IDLE, ST_ERASE, ST_VERIFY} seq_state_e;
  typedef logic [12:0] page_t;
  typedef logic [7:0]  count_t;
endpackage

// File: design/erase_timer_if.sv
`timescale 1ns/1ps
`default_nettype none
interface erase_timer_if;
  logic        start;
  logic [31:0] cycles;
  logic        done;
  modport seq   (output start, output cycles, input done);
  modport timer (input start, input cycles, output done);
endinterface
`default_nettype wire

// File: design/erase_timer.sv
`timescale 1ns/1ps
`default_nettype none
module erase_timer (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Sequencer side
  erase_timer_if.timer   tmr
);
  logic [31:0] count_reg;
  logic        done_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      count_reg <= 32'h0000_0000;
    end else if (tmr.start) begin
      count_reg <= tmr.cycles;
    end else if (count_reg != 32'h0000_0000) begin
      count_reg <= count_reg - 32'h0000_0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      done_reg <= 1'b0;
    end else begin
      done_reg <= !tmr.start && (count_reg == 32'h0000_0001);
    end
  end

  assign tmr.done = done_reg;

  timer_done_a: assert property (@(posedge clk) disable iff (rst)
    count_reg == 32'h0000_0001 && !tmr.start |=> tmr.done)
    else $error("Erase timer did not finish on its count.");
  timer_load_a: assert property (@(posedge clk) disable iff (rst)
    tmr.start |=> count_reg == $past(tmr.cycles) && !tmr.done)
    else $error("Erase timer did not load its count.");
endmodule
`default_nettype wire

// File: design/flash_erase_seq.sv
`timescale 1ns/1ps
`default_nettype none
`include "erase_defs.svh"
module flash_erase_seq #(
  parameter int unsigned PAGE_ERASE_CYCLES   = `PAGE_ERASE_MAX_MS * `CLK_KHZ,
  parameter int unsigned BLOCK_ERASE_CYCLES  = `BLOCK_ERASE_MAX_MS * `CLK_KHZ,
  parameter int unsigned SECTOR_ERASE_CYCLES = `SECTOR_ERASE_MAX_MS * `CLK_KHZ
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Serial link
  input  wire logic             cs_n,
  input  wire logic             sck,
  input  wire logic             mosi,
  // Configuration
  input  wire logic             binary_page_mode,
  // Array side
  output logic                  array_erase,
  output erase_pkg::page_t      erase_first_page,
  output erase_pkg::count_t     erase_page_count,
  output logic                  verify_active,
  output erase_pkg::page_t      verify_page,
  input  wire logic             verify_fail,
  // Status
  output logic                  ready,
  output logic                  erase_program_error_flag
);
  erase_timer_if tmr_if ();

  erase_timer u_timer (
    .clk (clk),
    .rst (rst),
    .tmr (tmr_if.timer)
  );

  logic [1:0]            cs_sync_reg;
  logic [1:0]            sck_sync_reg;
  logic [1:0]            mosi_sync_reg;
  logic                  cs_prev_reg;
  logic                  sck_prev_reg;
  logic [31:0]           shift_reg;
  logic [5:0]            bit_cnt_reg;
  erase_pkg::seq_state_e state_reg;
  erase_pkg::page_t      first_reg;
  erase_pkg::count_t     count_reg;
  erase_pkg::page_t      vpage_reg;
  logic                  erase_reg;
  logic                  verify_reg;
  logic                  ready_reg;
  logic                  error_reg;
  logic                  tstart_reg;
  logic [31:0]           tcycles_reg;
  logic [31:0]           busy_cnt_reg;
  logic [31:0]           op_max_reg;

  logic                  sck_rise;
  logic                  cs_rise;
  logic                  cs_fall;
  logic [7:0]            opcode;
  erase_pkg::page_t      page;
  erase_pkg::page_t      cmd_first;
  erase_pkg::count_t     cmd_count;
  logic [31:0]           cmd_max;
  logic                  cmd_valid;
  logic                  launch;
  logic                  verify_last;

  // Link pins come from the host's domain; the second stage is the only reader of the first.
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_sync_reg   <= 2'h3;
      sck_sync_reg  <= 2'h0;
      mosi_sync_reg <= 2'h0;
    end else begin
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      sck_sync_reg  <= {sck_sync_reg[0], sck};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cs_prev_reg  <= 1'b1;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg  <= cs_sync_reg[1];
      sck_prev_reg <= sck_sync_reg[1];
    end
  end

  assign sck_rise = sck_sync_reg[1] && !sck_prev_reg;
  assign cs_rise  = cs_sync_reg[1] && !cs_prev_reg;
  assign cs_fall  = !cs_sync_reg[1] && cs_prev_reg;

  // Mode 0 and 3 both sample data on the rising serial clock.
  always_ff @(posedge clk) begin
    if (rst) begin
      shift_reg <= 32'h0000_0000;
    end else if (!cs_sync_reg[1] && sck_rise) begin
      shift_reg <= {shift_reg[30:0], mosi_sync_reg[1]};
    end
  end

  always_ff @(posedge clk) begin
    if (rst || cs_fall) begin
      bit_cnt_reg <= 6'h00;
    end else if (!cs_sync_reg[1] && sck_rise && bit_cnt_reg != `CMD_BITS_MAX) begin
      bit_cnt_reg <= bit_cnt_reg + 6'h01;
    end
  end

  assign opcode = shift_reg[31:24];

  // The page field is chosen by page size before anything else is decoded.
  assign page = binary_page_mode ? shift_reg[`BIN_PAGE_MSB:`BIN_PAGE_LSB]
                                 : shift_reg[`STD_PAGE_MSB:`STD_PAGE_LSB];

  always_comb begin
    cmd_valid = 1'b1;
    cmd_first = page;
    cmd_count = `PAGE_COUNT_ONE;
    cmd_max   = PAGE_ERASE_CYCLES;
    case (opcode)
      `OP_PAGE_ERASE: begin
        cmd_first = page;
      end
      `OP_BLOCK_ERASE: begin
        cmd_first = {page[12:3], 3'h0};
        cmd_count = `BLOCK_PAGES;
        cmd_max   = BLOCK_ERASE_CYCLES;
      end
      `OP_SECTOR_ERASE: begin
        cmd_max = SECTOR_ERASE_CYCLES;
        if (page[12:7] != 6'h00) begin
          cmd_first = {page[12:7], 7'h00};
          cmd_count = `SECTOR_PAGES;
        end else if (page[6:3] == 4'h0) begin
          cmd_first = 13'h0000;
          cmd_count = `BLOCK_PAGES;
        end else begin
          cmd_first = `SECTOR0B_FIRST;
          cmd_count = `SECTOR0B_PAGES;
        end
      end
      default: begin
        cmd_valid = 1'b0;
      end
    endcase
  end

  // Commands arriving while busy are dropped; the host is expected to poll first.
  assign launch = cs_rise && cmd_valid && bit_cnt_reg == `CMD_BITS
                  && state_reg == erase_pkg::ST_IDLE;
  assign verify_last = vpage_reg == first_reg + 13'(count_reg) - 13'h0001;

  always_ff @(posedge clk) begin
    if (rst) begin
      state_reg <= erase_pkg::ST_IDLE;
    end else begin
      case (state_reg)
        erase_pkg::ST_IDLE: begin
          if (launch) begin
            state_reg <= erase_pkg::ST_ERASE;
          end
        end
        erase_pkg::ST_ERASE: begin
          if (tmr_if.done) begin
            state_reg <= erase_pkg::ST_VERIFY;
          end
        end
        erase_pkg::ST_VERIFY: begin
          if (verify_last) begin
            state_reg <= erase_pkg::ST_IDLE;
          end
        end
        default: begin
          state_reg <= erase_pkg::ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      first_reg   <= 13'h0000;
      count_reg   <= 8'h00;
      op_max_reg  <= 32'h0000_0000;
      tcycles_reg <= 32'h0000_0000;
    end else if (launch) begin
      first_reg   <= cmd_first;
      count_reg   <= cmd_count;
      op_max_reg  <= cmd_max;
      // Leave room for the verify pass so the whole job stays inside the limit.
      tcycles_reg <= cmd_max - `VERIFY_MARGIN;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tstart_reg <= 1'b0;
    end else begin
      tstart_reg <= launch;
    end
  end

  assign tmr_if.start  = tstart_reg;
  assign tmr_if.cycles = tcycles_reg;

  always_ff @(posedge clk) begin
    if (rst) begin
      erase_reg <= 1'b0;
    end else if (launch) begin
      erase_reg <= 1'b1;
    end else if (tmr_if.done) begin
      erase_reg <= 1'b0;
    end
  end

  // Every page of the range is checked, one per cycle, against the array's verdict.
  always_ff @(posedge clk) begin
    if (rst) begin
      verify_reg <= 1'b0;
      vpage_reg  <= 13'h0000;
    end else if (state_reg == erase_pkg::ST_ERASE && tmr_if.done) begin
      verify_reg <= 1'b1;
      vpage_reg  <= first_reg;
    end else if (verify_reg) begin
      verify_reg <= !verify_last;
      vpage_reg  <= verify_last ? vpage_reg : vpage_reg + 13'h0001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      ready_reg <= 1'b1;
    end else if (launch) begin
      ready_reg <= 1'b0;
    end else if (verify_reg && verify_last) begin
      ready_reg <= 1'b1;
    end
  end

  // A new erase clears the previous verdict; the failure set cannot meet that clear.
  always_ff @(posedge clk) begin
    if (rst) begin
      error_reg <= 1'b0;
    end else if (verify_reg && verify_fail) begin
      error_reg <= 1'b1;
    end else if (launch) begin
      error_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || ready_reg) begin
      busy_cnt_reg <= 32'h0000_0000;
    end else begin
      busy_cnt_reg <= busy_cnt_reg + 32'h0000_0001;
    end
  end

  assign array_erase              = erase_reg;
  assign erase_first_page         = first_reg;
  assign erase_page_count         = count_reg;
  assign verify_active            = verify_reg;
  assign verify_page              = vpage_reg;
  assign ready                    = ready_reg;
  assign erase_program_error_flag = error_reg;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  launch_busy_a: assert property (launch |=> !ready ##1 !ready)
    else $error("Ready did not drop at erase launch.");
  erase_busy_a: assert property (array_erase || verify_active |-> !ready)
    else $error("Ready shown during an erase.");
  busy_limit_a: assert property (!ready |-> busy_cnt_reg < op_max_reg)
    else $error("Erase ran past its maximum time.");
  std_page_a: assert property (launch && opcode == `OP_PAGE_ERASE && !binary_page_mode
    |=> erase_first_page == $past(shift_reg[`STD_PAGE_MSB:`STD_PAGE_LSB])
        && erase_page_count == `PAGE_COUNT_ONE)
    else $error("Standard page erase address wrong.");
  bin_page_a: assert property (launch && opcode == `OP_PAGE_ERASE && binary_page_mode
    |=> erase_first_page == $past(shift_reg[`BIN_PAGE_MSB:`BIN_PAGE_LSB])
        && erase_page_count == `PAGE_COUNT_ONE)
    else $error("Binary page erase address wrong.");
  block_align_a: assert property (launch && opcode == `OP_BLOCK_ERASE
    |=> erase_first_page[2:0] == 3'h0 && erase_page_count == `BLOCK_PAGES
        && erase_first_page[12:3] == $past(page[12:3]))
    else $error("Block erase range wrong.");
  sector_size_a: assert property (launch && opcode == `OP_SECTOR_ERASE
    |=> erase_page_count inside {`BLOCK_PAGES, `SECTOR0B_PAGES, `SECTOR_PAGES})
    else $error("Sector erase size wrong.");
  // The upper bound is taken one bit wider so that the last sector does not wrap to zero.
  sector_hit_a: assert property (launch && opcode == `OP_SECTOR_ERASE
    |=> $past(page) >= erase_first_page
        && $past(page) < {1'b0, erase_first_page} + 14'(erase_page_count))
    else $error("Sector does not hold the given address.");
  verify_error_a: assert property (verify_active && verify_fail
    |=> erase_program_error_flag)
    else $error("Verify failure not flagged.");
  ready_return_a: assert property (verify_active && verify_last |=> ready && !verify_active)
    else $error("Ready not restored after verify.");

  page_cover_c: cover property (launch && opcode == `OP_PAGE_ERASE);
  block_cover_c: cover property (launch && opcode == `OP_BLOCK_ERASE);
  sector_cover_c: cover property (launch && opcode == `OP_SECTOR_ERASE);
  error_cover_c: cover property (verify_active && verify_fail);
endmodule
`default_nettype wire

// File: verif/spi_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module spi_host_model (
  // Clock
  input  wire logic clk,
  // Serial link
  output logic      cs_n,
  output logic      sck,
  output logic      mosi
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    mosi = 1'b0;
  end

  // Mode 0, MSB first, 8 clk per bit; the clock stands still between frames.
  task automatic send(input logic [31:0] word, input int nbits);
    @(posedge clk);
    cs_n <= 1'b0;
    for (int i = 31; i > 31 - nbits; i--) begin
      mosi <= word[i];
      repeat (4) @(posedge clk);
      sck <= 1'b1;
      repeat (4) @(posedge clk);
      sck <= 1'b0;
    end
    repeat (4) @(posedge clk);
    cs_n <= 1'b1;
    // A released line must not keep showing the last bit.
    mosi <= ~mosi;
    repeat (4) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// File: verif/flash_page_block_sector_erase_tb.sv
`timescale 1ns/1ps
`default_nettype none
module flash_page_block_sector_erase_tb;
  localparam int PE = 400;
  localparam int BE = 500;
  localparam int SE = 600;
  logic              clk;
  logic              rst;
  logic              cs_n;
  logic              sck;
  logic              mosi;
  logic              mode;
  logic              array_erase;
  erase_pkg::page_t  erase_first_page;
  erase_pkg::count_t erase_page_count;
  logic              verify_active;
  erase_pkg::page_t  verify_page;
  logic              verify_fail;
  logic              ready;
  logic              erase_program_error_flag;
  logic              fail_en;
  erase_pkg::page_t  bad_page;
  logic [31:0]       seed;
  int                err_count;
  int                samples_checked;
  int                cycles;

  spi_host_model host (.clk(clk), .cs_n(cs_n), .sck(sck), .mosi(mosi));

  flash_erase_seq #(
    .PAGE_ERASE_CYCLES(PE), .BLOCK_ERASE_CYCLES(BE), .SECTOR_ERASE_CYCLES(SE)
  ) dut (
    .clk(clk), .rst(rst), .cs_n(cs_n), .sck(sck), .mosi(mosi),
    .binary_page_mode(mode), .array_erase(array_erase),
    .erase_first_page(erase_first_page), .erase_page_count(erase_page_count),
    .verify_active(verify_active), .verify_page(verify_page),
    .verify_fail(verify_fail), .ready(ready),
    .erase_program_error_flag(erase_program_error_flag)
  );

  // The array answers within the cycle, so this one input is combinational.
  assign verify_fail = fail_en & verify_active & (verify_page === bad_page);

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [20:0] exp_range(input logic [7:0] op, input logic [23:0] a,
                                            input logic bin);
    erase_pkg::page_t p;
    p = bin ? a[21:9] : a[22:10];
    if (op == 8'h81) return {p, 8'h01};
    if (op == 8'h50) return {p & 13'h1FF8, 8'h08};
    if (p[12:7] != 6'h00) return {p[12:7], 7'h00, 8'h80};
    if (p[6:3] == 4'h0) return {13'h0000, 8'h08};
    return {13'h0008, 8'h78};
  endfunction

  task automatic check(input string name, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (e !== g) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", name, e, g);
    end
  endtask

  task automatic run_cmd(input logic [7:0] op, input logic [23:0] a, input logic bin,
                         input logic fail);
    logic [20:0]      e;
    int               n;
    int               vcnt;
    int               lim;
    erase_pkg::page_t v0;
    e = exp_range(op, a, bin);
    lim = (op == 8'h81) ? PE : (op == 8'h50) ? BE : SE;
    seed = lfsr(seed);
    mode <= bin;
    fail_en <= fail;
    bad_page <= e[20:8] + 13'(seed % e[7:0]);
    host.send({op, a}, 32);
    n = 0;
    while (ready !== 1'b0 && n < 40) begin
      @(posedge clk);
      #1 n++;
    end
    check("busy_start", 1, n < 40);
    check("first_page", e[20:8], erase_first_page);
    check("page_count", e[7:0], erase_page_count);
    check("erase_start", 1, array_erase);
    n = 0;
    vcnt = 0;
    v0 = 13'h0000;
    while (ready === 1'b0 && n < 2000) begin
      if (verify_active === 1'b1) begin
        if (vcnt == 0) v0 = verify_page;
        vcnt++;
      end
      @(posedge clk);
      #1 n++;
    end
    check("erase_time", 1, n <= lim);
    check("verify_pages", e[7:0], vcnt);
    check("verify_first", e[20:8], v0);
    check("error_flag", fail, erase_program_error_flag);
    check("erase_idle", 0, array_erase);
  endtask

  task automatic refuse(input logic [31:0] w, input int nbits);
    logic stayed;
    stayed = 1'b1;
    host.send(w, nbits);
    repeat (40) begin
      @(posedge clk);
      #1 stayed &= (ready === 1'b1) & (array_erase === 1'b0);
    end
    check("refused", 1, stayed);
  endtask

  task automatic results();
    if (err_count == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  always @(posedge clk) begin
    cycles++;
    if (cycles == 90000) begin
      err_count++;
      results();
    end
  end

  initial begin
    logic [7:0] ops [3];
    ops = '{8'h81, 8'h50, 8'h7C};
    rst = 1'b1;
    mode = 1'b0;
    fail_en = 1'b0;
    bad_page = 13'h0000;
    seed = 32'hCF4F2EE6;
    err_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("ready_reset", 1, ready);
    check("flag_reset", 0, erase_program_error_flag);
    run_cmd(8'h7C, 24'h000000, 1'b0, 1'b0);
    run_cmd(8'h7C, 24'h002000, 1'b0, 1'b1);
    run_cmd(8'h7C, 24'h003000, 1'b1, 1'b0);
    run_cmd(8'h7C, 24'hBFFFFF, 1'b1, 1'b1);
    run_cmd(8'h50, 24'h7FFC00, 1'b0, 1'b1);
    run_cmd(8'h81, 24'hFFFFFF, 1'b1, 1'b0);
    refuse(32'h82000000, 32);
    refuse(32'h81000400, 31);
    // Reset in the middle of a sector erase must bring every status output home.
    fail_en <= 1'b0;
    host.send({8'h7C, 24'h7FFFFF}, 32);
    repeat (20) @(posedge clk);
    check("busy_mid", 0, ready);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1 check("ready_mid_reset", 1, ready);
    check("erase_mid_reset", 0, array_erase);
    check("verify_mid_reset", 0, verify_active);
    check("count_mid_reset", 0, erase_page_count);
    check("flag_mid_reset", 0, erase_program_error_flag);
    for (int i = 0; i < 36; i++) begin
      seed = lfsr(seed);
      run_cmd(ops[seed[7:0] % 3], seed[31:8], seed[3], seed[4]);
    end
    results();
  end
endmodule
`default_nettype wire
